// >>> src/rcv_cause_rec.sv
`timescale 1ns/1ps
module rcv_cause_rec (
    input wire logic pclk,
    input wire logic presetn,
    rcv_ev_if.rec bus
);
    logic [rcv_pkg::NCAUSE-1:0] pend_r;
    genvar i;
    generate
        for (i = 0; i < rcv_pkg::NCAUSE; i++) begin : g_flag
            if (rcv_pkg::CAUSE_VALID[i]) begin : g_live
                // a new event beats the read-clear of the same flag
                always_ff @(posedge pclk or negedge presetn) begin
                    if (!presetn) begin
                        pend_r[i] <= 1'b0;
                    end else if (bus.ev[i]) begin
                        pend_r[i] <= 1'b1;
                    end else if (bus.take[i]) begin
                        pend_r[i] <= 1'b0;
                    end
                end
            end else begin : g_resv
                assign pend_r[i] = 1'b0;
            end
        end
    endgenerate
    assign bus.pend = pend_r;
endmodule

// >>> src/rcv_ev_if.sv
`timescale 1ns/1ps
interface rcv_ev_if;
    logic [rcv_pkg::NCAUSE-1:0] ev;
    logic [rcv_pkg::NCAUSE-1:0] pend;
    logic [rcv_pkg::NCAUSE-1:0] take;
    modport src(output ev, output take, input pend);
    modport rec(input ev, input take, output pend);
endinterface

// >>> src/rcv_pkg.sv
package rcv_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // printed offset 015Eh is not a multiple of four: kept as index
    localparam logic [11:0] VEC_IDX = 12'h15E;
    localparam logic [13:0] VEC_ADDR = 14'(VEC_IDX) << 2;
    localparam logic [13:0] IRQ_STAT_ADDR = 14'h0800;
    localparam logic [13:0] IRQ_MASK_ADDR = 14'h0804;
    localparam logic [13:0] WDT_CTRL_ADDR = 14'h0808;
    localparam logic [13:0] CAUSE_ADDR = 14'h080C;
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] MASK_RESET = 16'h0000;
    localparam logic [15:0] WDT_CTRL_RESET = 16'h0000;
    localparam int WDT_MODE_BIT = 0;
    localparam int WDT_EN_BIT = 1;

    // ------------------------------------------------------------
    // cause indices, code = 2*(index+1), lower index wins
    // ------------------------------------------------------------
    localparam int NCAUSE = 18;
    localparam int C_BROWNOUT = 0;
    localparam int C_RSTPIN = 1;
    localparam int C_SOFT_BROWN = 2;
    localparam int C_LPM_WAKE = 3;
    localparam int C_SECURITY = 4;
    localparam int C_SVSH = 6;
    localparam int C_SOFT_POR = 9;
    localparam int C_WDT_EXP = 10;
    localparam int C_WDT_KEY = 11;
    localparam int C_NVM_KEY = 12;
    localparam int C_NVM_ECC = 13;
    localparam int C_PERIPH_FETCH = 14;
    localparam int C_PMM_KEY = 15;
    localparam int C_FLL_UNLOCK = 17;
    // reserved codes 0Ch, 10h, 12h, 22h are never generated
    localparam logic [NCAUSE-1:0] CAUSE_VALID = 18'h2FE5F;

    typedef enum logic [1:0] {
        RCV_CLS_NONE = 2'h0,
        RCV_CLS_BROWN = 2'h1,
        RCV_CLS_PWRON = 2'h3,
        RCV_CLS_CLEAR = 2'h2
    } rcv_class_t;

    // watchdog interval in cycles of pclk
    localparam int WDT_INTERVAL = 32768;
endpackage

// >>> src/rcv_top.sv
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - a 16-bit reset-cause vector register at index 015Eh reports the recorded cause as an even code.
// - every cause is tagged brownout, power-on or power-up-clear class as the reset it triggers.
// - a high-side supply monitor event gives a brownout-class reset and code 0Eh.
// - a software brownout request gives a brownout-class reset, recorded above low-power wakeup.
// - a software power-on request gives a power-on-class reset and code 14h.
// - in watchdog mode an unserviced interval forces a reset instead of only an interrupt.
// - a watchdog time-out is a power-up-clear-class reset with code 16h.
// - a watchdog control write with a wrong key gives a power-up-clear reset and code 18h.
// - a memory controller control write with a wrong key gives a power-up-clear reset and code 1Ah.
// - an uncorrectable memory bit error is recorded as a cause with code 1Ch.
// - a fetch from the peripheral region gives a power-up-clear reset and code 1Eh.
// - a power manager control write with a wrong key gives a power-up-clear reset and code 20h.
module rcv_top #(
    parameter int WDT_CYCLES = rcv_pkg::WDT_INTERVAL
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic brownout_pin_evt,
    input wire logic rst_pin_evt,
    input wire logic soft_brownout_request,
    input wire logic lpm_wake_evt,
    input wire logic security_evt,
    input wire logic supply_monitor_flag,
    input wire logic soft_poweron_request,
    input wire logic watchdog_key_bad,
    input wire logic nvm_ctrl_key_bad,
    input wire logic nvm_ecc_uncorr,
    input wire logic periph_fetch,
    input wire logic power_mgr_key_bad,
    input wire logic fll_unlock,
    input wire logic wdt_service,
    output logic [1:0] reset_req_class,
    output logic reset_req,
    output logic irq
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    localparam int NIN = 14;
    logic [NIN-1:0] raw_in;
    logic [NIN-1:0] sync1_r;
    logic [NIN-1:0] sync2_r;
    logic [NIN-1:0] sync3_r;
    logic [NIN-1:0] rise;

    assign raw_in = {wdt_service, fll_unlock, power_mgr_key_bad, periph_fetch, nvm_ecc_uncorr,
                     nvm_ctrl_key_bad, watchdog_key_bad, soft_poweron_request, supply_monitor_flag,
                     security_evt, lpm_wake_evt, soft_brownout_request, rst_pin_evt, brownout_pin_evt};

    // pins come from other domains; only the second and third stages feed logic
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end
    assign rise = sync2_r & ~sync3_r;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic wr_acc;
    logic rd_acc;
    logic [15:0] wdata16;
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign wdata16 = pwdata[15:0];

    function automatic logic known_addr(input logic [13:0] a);
        known_addr = (a == rcv_pkg::VEC_ADDR) || (a == rcv_pkg::IRQ_STAT_ADDR) ||
                     (a == rcv_pkg::IRQ_MASK_ADDR) || (a == rcv_pkg::WDT_CTRL_ADDR) ||
                     (a == rcv_pkg::CAUSE_ADDR);
    endfunction

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    logic [15:0] wdt_ctrl_r;
    logic [31:0] wdt_cnt_r;
    logic wdt_expire;
    logic wdt_irq_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_ctrl_r <= rcv_pkg::WDT_CTRL_RESET;
        end else if (wr_acc && paddr == rcv_pkg::WDT_CTRL_ADDR) begin
            wdt_ctrl_r <= wdata16;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wdt_cnt_r <= '0;
        end else if (!wdt_ctrl_r[rcv_pkg::WDT_EN_BIT] || rise[13] || wdt_cnt_r == 32'(WDT_CYCLES - 1)) begin
            wdt_cnt_r <= '0;
        end else begin
            wdt_cnt_r <= wdt_cnt_r + 32'h1;
        end
    end

    logic wdt_elapsed;
    assign wdt_elapsed = wdt_ctrl_r[rcv_pkg::WDT_EN_BIT] && !rise[13] &&
                         wdt_cnt_r == 32'(WDT_CYCLES - 1);
    // mode bit set: reset; clear: interval timer interrupt only
    assign wdt_expire = wdt_elapsed && wdt_ctrl_r[rcv_pkg::WDT_MODE_BIT];
    assign wdt_irq_evt = wdt_elapsed && !wdt_ctrl_r[rcv_pkg::WDT_MODE_BIT];

    // ------------------------------------------------------------
    // cause recording
    // ------------------------------------------------------------
    rcv_ev_if evb();
    logic [rcv_pkg::NCAUSE-1:0] ev_vec;
    logic [rcv_pkg::NCAUSE-1:0] take_vec;
    logic [rcv_pkg::NCAUSE-1:0] pend;

    always_comb begin
        ev_vec = '0;
        ev_vec[rcv_pkg::C_BROWNOUT] = rise[0];
        ev_vec[rcv_pkg::C_RSTPIN] = rise[1];
        ev_vec[rcv_pkg::C_SOFT_BROWN] = rise[2];
        ev_vec[rcv_pkg::C_LPM_WAKE] = rise[3];
        ev_vec[rcv_pkg::C_SECURITY] = rise[4];
        ev_vec[rcv_pkg::C_SVSH] = rise[5];
        ev_vec[rcv_pkg::C_SOFT_POR] = rise[6];
        ev_vec[rcv_pkg::C_WDT_EXP] = wdt_expire;
        ev_vec[rcv_pkg::C_WDT_KEY] = rise[7];
        ev_vec[rcv_pkg::C_NVM_KEY] = rise[8];
        ev_vec[rcv_pkg::C_NVM_ECC] = rise[9];
        ev_vec[rcv_pkg::C_PERIPH_FETCH] = rise[10];
        ev_vec[rcv_pkg::C_PMM_KEY] = rise[11];
        ev_vec[rcv_pkg::C_FLL_UNLOCK] = rise[12];
    end

    assign evb.ev = ev_vec;
    assign evb.take = take_vec;
    assign pend = evb.pend;

    rcv_cause_rec u_rec (
        .pclk(pclk),
        .presetn(presetn),
        .bus(evb)
    );

    // class that each cause triggers
    function automatic rcv_pkg::rcv_class_t cause_class(input int idx);
        if (idx <= rcv_pkg::C_SVSH) begin
            cause_class = rcv_pkg::RCV_CLS_BROWN;
        end else if (idx == rcv_pkg::C_SOFT_POR) begin
            cause_class = rcv_pkg::RCV_CLS_PWRON;
        end else begin
            cause_class = rcv_pkg::RCV_CLS_CLEAR;
        end
    endfunction

    // lowest index pending wins
    logic [15:0] top_code;
    logic [4:0] top_idx;
    logic top_any;
    always_comb begin
        top_code = rcv_pkg::VEC_RESET;
        top_idx = '0;
        top_any = 1'b0;
        for (int k = rcv_pkg::NCAUSE - 1; k >= 0; k--) begin
            if (pend[k]) begin
                top_code = 16'((k + 1) * 2);
                top_idx = 5'(k);
                top_any = 1'b1;
            end
        end
    end

    // the flag cleared is the one whose code was latched at setup, even if a
    // more urgent cause lands during the access cycle
    logic [4:0] rd_idx_r;
    logic rd_any_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_idx_r <= '0;
            rd_any_r <= 1'b0;
        end else if (psel && !penable) begin
            rd_idx_r <= top_idx;
            rd_any_r <= top_any;
        end
    end

    logic vec_read;
    assign vec_read = rd_acc && paddr == rcv_pkg::VEC_ADDR;
    always_comb begin
        take_vec = '0;
        if (vec_read && rd_any_r) begin
            take_vec[rd_idx_r] = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // reset request output
    // ------------------------------------------------------------
    // most severe class among this cycle's events
    rcv_pkg::rcv_class_t ev_class;
    always_comb begin
        ev_class = rcv_pkg::RCV_CLS_NONE;
        for (int k = rcv_pkg::NCAUSE - 1; k >= 0; k--) begin
            if (ev_vec[k]) begin
                ev_class = cause_class(k);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req <= 1'b0;
            reset_req_class <= rcv_pkg::RCV_CLS_NONE;
        end else begin
            reset_req <= ev_class != rcv_pkg::RCV_CLS_NONE;
            reset_req_class <= ev_class;
        end
    end

    // ------------------------------------------------------------
    // interrupt status and mask
    // ------------------------------------------------------------
    // bit0 new cause recorded, bit1 interval timer elapsed
    logic [15:0] stat_r;
    logic [15:0] mask_r;
    logic [15:0] stat_set;
    logic [15:0] stat_clr;
    logic [15:0] mask_now;
    assign stat_set = {14'h0, wdt_irq_evt, |ev_vec};
    assign stat_clr = (wr_acc && paddr == rcv_pkg::IRQ_STAT_ADDR) ? wdata16 : 16'h0000;
    assign mask_now = (wr_acc && paddr == rcv_pkg::IRQ_MASK_ADDR) ? wdata16 : mask_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stat_r <= '0;
        end else begin
            // set wins over a simultaneous write-one-to-clear
            stat_r <= (stat_r & ~stat_clr) | stat_set;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_r <= rcv_pkg::MASK_RESET;
        end else if (wr_acc && paddr == rcv_pkg::IRQ_MASK_ADDR) begin
            mask_r <= wdata16;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            // follows the values status and mask take at this edge, so it drops with the clearing write
            irq <= |(((stat_r & ~stat_clr) | stat_set) & mask_now);
        end
    end

    // ------------------------------------------------------------
    // apb read and answer
    // ------------------------------------------------------------
    // pready rises in the first access cycle: no wait state is ever inserted
    logic setup_cyc;
    assign setup_cyc = psel && !penable;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else begin
            pready <= setup_cyc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup_cyc && !known_addr(paddr);
        end
    end

    // unmapped writes load zero too, so an error answer never carries stale data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (setup_cyc && (!pwrite || !known_addr(paddr))) begin
            case (paddr)
                rcv_pkg::VEC_ADDR: prdata <= {16'h0000, top_code};
                rcv_pkg::IRQ_STAT_ADDR: prdata <= {16'h0000, stat_r | stat_set};
                rcv_pkg::IRQ_MASK_ADDR: prdata <= {16'h0000, mask_r};
                rcv_pkg::WDT_CTRL_ADDR: prdata <= {16'h0000, wdt_ctrl_r};
                rcv_pkg::CAUSE_ADDR: prdata <= {14'h0, pend};
                default: prdata <= '0;
            endcase
        end
    end
endmodule

// >>> verification/rcv_top_assertions.sv
`timescale 1ns/1ps
module rcv_top_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic brownout_pin_evt,
    input wire logic supply_monitor_flag,
    input wire logic soft_brownout_request,
    input wire logic soft_poweron_request,
    input wire logic watchdog_key_bad,
    input wire logic nvm_ctrl_key_bad,
    input wire logic nvm_ecc_uncorr,
    input wire logic periph_fetch,
    input wire logic power_mgr_key_bad,
    input wire logic reset_req,
    input wire logic [1:0] reset_req_class
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic vec_rd;
    assign vec_rd = psel && penable && pready && !pwrite && paddr == rcv_pkg::VEC_ADDR;
    sequence req_s(logic [1:0] cls);
        reset_req && reset_req_class == cls;
    endsequence
    // event passes a two-stage sync and an edge detect before the request
    property cls_p(logic e, logic [1:0] cls);
        $rose(e) |-> ##[2:6] req_s(cls);
    endproperty
    vec_even_a: assert property (vec_rd |-> !prdata[0] && prdata[31:16] == 16'h0000)
        else $error("vector code not even");
    vec_reserved_a: assert property (
        vec_rd |-> !(prdata[15:0] inside {16'h000C, 16'h0010, 16'h0012, 16'h0022}) && prdata[15:0] <= 16'h0024)
        else $error("reserved vector code");
    ready_access_a: assert property (pready |-> psel && penable) else $error("pready outside access");
    ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
    err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000) else $error("error with data");
    pin_brown_a: assert property (cls_p(brownout_pin_evt, 2'h1)) else $error("brownout class wrong");
    svsh_brown_a: assert property (cls_p(supply_monitor_flag, 2'h1)) else $error("supply class wrong");
    soft_brown_a: assert property (cls_p(soft_brownout_request, 2'h1)) else $error("soft brownout class");
    soft_pwron_a: assert property (cls_p(soft_poweron_request, 2'h3)) else $error("soft power-on class");
    ecc_class_a: assert property (cls_p(nvm_ecc_uncorr, 2'h2)) else $error("ecc class wrong");
    wdt_key_a: assert property (cls_p(watchdog_key_bad, 2'h2)) else $error("watchdog key class");
    nvm_key_a: assert property (cls_p(nvm_ctrl_key_bad, 2'h2)) else $error("nvm key class");
    fetch_clear_a: assert property (cls_p(periph_fetch, 2'h2)) else $error("fetch class wrong");
    pmm_key_a: assert property (cls_p(power_mgr_key_bad, 2'h2)) else $error("pmm key class");
endmodule

// >>> verification/rcv_top_tb_top.sv
`timescale 1ns/1ps
module rcv_top_tb_top;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, wdt_service = 0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, reset_req, irq, err;
    logic [1:0] reset_req_class;
    logic [1:0] last_cls = '0;
    logic [12:0] ev = '0, sub;
    int errors = 0, checked = 0, cyc = 0;
    int idx [13] = '{0, 1, 2, 3, 4, 6, 9, 11, 12, 13, 14, 15, 17};
    rcv_top #(.WDT_CYCLES(16)) i_rcv_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .brownout_pin_evt(ev[0]), .rst_pin_evt(ev[1]), .soft_brownout_request(ev[2]), .lpm_wake_evt(ev[3]),
        .security_evt(ev[4]), .supply_monitor_flag(ev[5]), .soft_poweron_request(ev[6]),
        .watchdog_key_bad(ev[7]), .nvm_ctrl_key_bad(ev[8]), .nvm_ecc_uncorr(ev[9]), .periph_fetch(ev[10]),
        .power_mgr_key_bad(ev[11]), .fll_unlock(ev[12]), .wdt_service(wdt_service),
        .reset_req_class(reset_req_class), .reset_req(reset_req), .irq(irq));
    initial forever #10 pclk = ~pclk;
    always @(posedge pclk) if (reset_req === 1'b1) last_cls <= reset_req_class;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] code(int i);
        return 32'(2 * (idx[i] + 1));
    endfunction
    function automatic logic [31:0] flags(logic [12:0] s);
        logic [31:0] f;
        f = '0;
        for (int i = 0; i < 13; i++) if (s[i]) f[idx[i]] = 1'b1;
        return f;
    endfunction
    task automatic complete_run();
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            errors = errors + 1;
            complete_run();
        end
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one idle edge after release so the next setup never lands in the same step
    task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string nm, input logic [13:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    // events rise one edge apart so each gets its own request cycle
    task automatic fire(input logic [12:0] s);
        for (int i = 0; i < 13; i++) if (s[i]) begin
            ev[i] <= 1'b1;
            @(posedge pclk);
        end
        repeat (3) @(posedge pclk);
        ev <= '0;
        repeat (6) @(posedge pclk);
    endtask
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(22));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        rdchk("mask", rcv_pkg::IRQ_MASK_ADDR, 32'(rcv_pkg::MASK_RESET));
        rdchk("wdt_ctrl", rcv_pkg::WDT_CTRL_ADDR, 32'(rcv_pkg::WDT_CTRL_RESET));
        apb(1'b0, 14'h0400, 32'h0000_0000);
        chk("slverr", 32'h0000_0001, 32'(err));
        chk("unmapped", 32'h0000_0000, rd);
        apb(1'b1, 14'h0400, 32'hFFFF_FFFF);
        chk("slverr", 32'h0000_0001, 32'(err));
        for (int i = 0; i < 13; i++) begin
            fire(13'h0001 << i);
            rdchk("vector", rcv_pkg::VEC_ADDR, code(i));
            rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        end
        apb(1'b1, rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
        apb(1'b1, rcv_pkg::IRQ_MASK_ADDR, 32'h0000_0001);
        fire(13'h0001);
        chk("irq", 32'h0000_0001, 32'(irq));
        apb(1'b1, rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
        chk("irq", 32'h0000_0000, 32'(irq));
        apb(1'b1, rcv_pkg::IRQ_MASK_ADDR, 32'h0000_0000);
        fire(13'h0001);
        chk("irq", 32'h0000_0000, 32'(irq));
        rdchk("status", rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0002);
        apb(1'b1, rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0001);
        for (int k = 0; k < 20; k++) begin
            sub = (k == 0) ? 13'h1FFF : 13'($urandom());
            fire(sub);
            rdchk("cause", rcv_pkg::CAUSE_ADDR, flags(sub));
            for (int i = 0; i < 13; i++) if (sub[i]) rdchk("vector", rcv_pkg::VEC_ADDR, code(i));
            rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        end
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0003);
        repeat (24) @(posedge pclk);
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0000);
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0016);
        chk("class", 32'(rcv_pkg::RCV_CLS_CLEAR), 32'(last_cls));
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        apb(1'b1, rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0003);
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0002);
        repeat (24) @(posedge pclk);
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0000);
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        rdchk("status", rcv_pkg::IRQ_STAT_ADDR, 32'h0000_0002);
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0003);
        repeat (6) begin
            repeat (5) @(posedge pclk);
            wdt_service <= 1'b1;
            repeat (2) @(posedge pclk);
            wdt_service <= 1'b0;
        end
        apb(1'b1, rcv_pkg::WDT_CTRL_ADDR, 32'h0000_0000);
        rdchk("vector", rcv_pkg::VEC_ADDR, 32'h0000_0000);
        complete_run();
    end
endmodule
bind rcv_top rcv_top_assertions i_rcv_top_assertions (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .brownout_pin_evt(brownout_pin_evt), .supply_monitor_flag(supply_monitor_flag),
    .soft_brownout_request(soft_brownout_request), .soft_poweron_request(soft_poweron_request),
    .watchdog_key_bad(watchdog_key_bad), .nvm_ctrl_key_bad(nvm_ctrl_key_bad), .nvm_ecc_uncorr(nvm_ecc_uncorr),
    .periph_fetch(periph_fetch),
    .power_mgr_key_bad(power_mgr_key_bad), .reset_req(reset_req), .reset_req_class(reset_req_class));
